// file: bench/ranked_io_trigger_terminals_test.sv
`timescale 1ns/1ns
module ranked_io_trigger_terminals_test;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              ce = 1'b1;
  rit_pkg::rit_cfg_t cfg = rit_pkg::CFG_RST;
  rit_pkg::rit_cfg_t cfg_o;
  logic              cfg_we = 1'b0;
  logic [2:0]        int_first_rank_source_select = 3'h0;
  logic [2:0]        fire = 3'h0;
  logic [2:0]        pin_n;
  logic [2:0]        outs;
  logic [15:0]       in_ch = 16'h0000;
  logic [15:0]       out_data = 16'h0000;
  logic              out_we = 1'b0;
  logic [15:0]       r1i, r2i, r1o, out_ch;
  int                n_fail = 0;
  int                cmp_count = 0;
  int                cyc = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  rit_trigger_terminals dut_u
  (
    .CLK_I(clk), .SRST_I(srst), .CE_I(ce), .CFG_I(cfg), .CFG_WE_I(cfg_we),
    .INT_FIRST_FIRST_RANK_SOURCE_SELECT_I(int_first_rank_source_select[0]), .INT_SECOND_IN_FIRST_RANK_SOURCE_SELECT_I(int_first_rank_source_select[1]),
    .INT_SECOND_OUT_FIRST_RANK_SOURCE_SELECT_I(int_first_rank_source_select[2]), .INPUT_CHANNELS_I(in_ch),
    .FIRST_OUT_DATA_I(out_data), .FIRST_OUT_WE_I(out_we),
    .FIRST_IN_FIRST_RANK_SOURCE_SELECT_N_I(pin_n[0]), .SECOND_IN_FIRST_RANK_SOURCE_SELECT_N_I(pin_n[1]),
    .SECOND_OUT_FIRST_RANK_SOURCE_SELECT_N_I(pin_n[2]), .FIRST_IN_FIRST_RANK_SOURCE_SELECT_N_O(outs[0]),
    .SECOND_IN_FIRST_RANK_SOURCE_SELECT_N_O(outs[1]), .SECOND_OUT_FIRST_RANK_SOURCE_SELECT_N_O(outs[2]), .CFG_O(cfg_o),
    .FIRST_IN_RANK_O(r1i), .SECOND_IN_RANK_O(r2i), .FIRST_OUT_RANK_O(r1o),
    .OUTPUT_CHANNELS_O(out_ch)
  );

  rit_ext_source src_u (.CLK_I(clk), .FIRE_I(fire), .LOW_LEN_I(8'h50), .FIRST_RANK_SOURCE_SELECT_N_O(pin_n));

  task automatic report_and_stop();
    $display("counts: %0d mismatches, %0d comparisons", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic set_cfg(input rit_pkg::rit_cfg_t c);
    @(posedge clk) cfg <= c;
    cfg_we <= 1'b1;
    @(posedge clk) cfg_we <= 1'b0;
  endtask

  task automatic fire_int(input int i);
    @(posedge clk) int_first_rank_source_select[i] <= 1'b1;
    @(posedge clk) int_first_rank_source_select[i] <= 1'b0;
  endtask

  // wait for an out pin to fall, then count its low cycles
  task automatic measure(input int i, output int w);
    w = 0;
    for (int k = 0; k < 8 && outs[i] !== 1'b0; k++) @(negedge clk);
    while (outs[i] === 1'b0 && w < 200)
    begin
      @(negedge clk);
      w++;
    end
  endtask

  task automatic t_internal();
    int w;
    in_ch <= 16'ha5c3;
    fire_int(0);
    measure(0, w);
    check(r1i, 16'ha5c3);
    check(16'(w), 16'h0032);
    check(16'(w * 40 >= 1700 && w * 40 <= 2800), 16'h0001);
    fire_int(1);
    measure(1, w);
    check(r2i, 16'ha5c3);
    check(16'(w), 16'h0032);
    @(posedge clk) out_data <= 16'h3c5a;
    out_we <= 1'b1;
    @(posedge clk) out_we <= 1'b0;
    fire_int(2);
    measure(2, w);
    check(out_ch, 16'h3c5a);
    check(r1o, 16'h3c5a);
    check(16'(w), 16'h0032);
  endtask

  task automatic t_external();
    int w;
    set_cfg('{rit_pkg::SRC_EXTERNAL, rit_pkg::SRC_EXTERNAL, rit_pkg::SRC_EXTERNAL,
              rit_pkg::STYLE_PULSE, rit_pkg::STYLE_PULSE});
    in_ch <= 16'h0ff1;
    @(posedge clk) out_data <= 16'h8001;
    out_we <= 1'b1;
    @(posedge clk) out_we <= 1'b0;
    // internal trigger must be ignored while the source is external
    fire_int(0);
    repeat (4) @(negedge clk);
    check(r1i, 16'ha5c3);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk) fire[i] <= 1'b1;
      @(posedge clk) fire[i] <= 1'b0;
      measure(i, w);
      check(16'(w), 16'h0032);
      repeat (30) @(negedge clk);
      check(16'(outs[i]), 16'h0001);
    end
    check(r1i, 16'h0ff1);
    check(r2i, 16'h0ff1);
    check(out_ch, 16'h8001);
  endtask

  task automatic t_edge_style();
    int w;
    set_cfg('{rit_pkg::SRC_INTERNAL, rit_pkg::SRC_INTERNAL, rit_pkg::SRC_INTERNAL,
              rit_pkg::STYLE_EDGE, rit_pkg::STYLE_EDGE});
    fire_int(0);
    fire_int(2);
    fire_int(1);
    measure(1, w);
    check(16'(w), 16'h0032);
    repeat (20) @(negedge clk);
    check(16'(outs), 16'h0002);
    set_cfg(rit_pkg::CFG_RST);
    fire_int(0);
    fire_int(2);
    repeat (60) @(negedge clk);
    check(16'(outs), 16'h0007);
  endtask

  // clock enable low freezes a running pulse; a mid-run reset restores internal sources
  task automatic t_freeze_reset();
    int w;
    in_ch <= 16'h1234;
    fire_int(0);
    repeat (10) @(negedge clk);
    @(posedge clk) ce <= 1'b0;
    int_first_rank_source_select[1] <= 1'b1;
    repeat (100) @(posedge clk);
    int_first_rank_source_select[1] <= 1'b0;
    @(posedge clk) ce <= 1'b1;
    @(negedge clk);
    check(16'(outs), 16'h0006);
    check(r2i, 16'h0ff1);
    // 10 cycles ran before the freeze, no frozen cycle is counted here
    measure(0, w);
    check(16'(w), 16'h0028);
    set_cfg('{rit_pkg::SRC_EXTERNAL, rit_pkg::SRC_EXTERNAL, rit_pkg::SRC_EXTERNAL,
              rit_pkg::STYLE_EDGE, rit_pkg::STYLE_EDGE});
    @(posedge clk) srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    in_ch <= 16'h5a5a;
    @(negedge clk);
    check(16'(cfg_o), 16'(rit_pkg::CFG_RST));
    check(16'(outs), 16'h0007);
    fire_int(0);
    @(negedge clk);
    check(r1i, 16'h5a5a);
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check(16'(cfg_o), 16'(rit_pkg::CFG_RST));
    check(16'(outs), 16'h0007);
    t_internal();
    t_external();
    t_edge_style();
    t_freeze_reset();
    report_and_stop();
  end
endmodule

// file: bench/rit_ext_source.sv
`timescale 1ns/1ns
module rit_ext_source
(
  input  wire logic       CLK_I,
  input  wire logic [2:0] FIRE_I,
  input  wire logic [7:0] LOW_LEN_I,
  output logic      [2:0] FIRST_RANK_SOURCE_SELECT_N_O
);
  logic [7:0] cnt_r [3] = '{default: 8'h00};
  // each pin rests high on its pull-up and falls for LOW_LEN_I cycles per fire
  always @(posedge CLK_I)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (FIRE_I[i])
        cnt_r[i] <= LOW_LEN_I;
      else if (cnt_r[i] != 8'h00)
        cnt_r[i] <= cnt_r[i] - 8'h01;
    end
  end
  // pin level from the hold counters
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      FIRST_RANK_SOURCE_SELECT_N_O[i] = (cnt_r[i] == 8'h00);
  end
endmodule

// file: logic/rit_pkg.sv
package rit_pkg;

  // trigger source and output style selections
  typedef enum logic
  {
    SRC_INTERNAL = 1'b0,
    SRC_EXTERNAL = 1'b1
  } rit_src_t;

  typedef enum logic
  {
    STYLE_PULSE = 1'b0,
    STYLE_EDGE  = 1'b1
  } rit_style_t;

  // pulse generator states
  typedef enum logic [1:0]
  {
    PG_IDLE = 2'b00,
    PG_LOW  = 2'b01,
    PG_HELD = 2'b10
  } rit_pg_state_t;

  // configuration carried as one group
  typedef struct packed
  {
    rit_src_t   first_rank_source_select;
    rit_src_t   second_rank_in_source_select;
    rit_src_t   second_rank_out_source_select;
    rit_style_t first_rank_style;
    rit_style_t second_rank_out_style;
  } rit_cfg_t;

  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned CHAN_W       = 16;
  // pulse width in nanoseconds: nominal 2000, window 1700..2800
  localparam int unsigned PULSE_NOM_NS = 2000;
  localparam int unsigned PULSE_MIN_NS = 1700;
  localparam int unsigned PULSE_MAX_NS = 2800;
  localparam int unsigned PULSE_CYC    = (PULSE_NOM_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned PULSE_MIN_CYC =
    (PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PULSE_MAX_CYC = (PULSE_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned CNT_W        = 7;
  localparam logic [CNT_W-1:0] PULSE_LEN = CNT_W'(PULSE_CYC);

  // reset values
  localparam logic [CHAN_W-1:0] RANK_RST = 16'h0000;
  localparam rit_cfg_t CFG_RST = '{SRC_INTERNAL, SRC_INTERNAL, SRC_INTERNAL,
                                   STYLE_PULSE, STYLE_PULSE};

endpackage

// file: logic/rit_trigger_terminals.sv
`timescale 1ns/1ns
// Overview of operation
// - external first-rank source takes first-rank triggers from its terminal IN pin.
// - each first-rank trigger drives first-rank OUT low, pulse or edge by style.
// - every trigger pulse lasts nominally 2 us, within 1.7 to 2.8 us.
// - external second-rank source takes second-rank input triggers from its IN pin.
// - each second-rank input trigger gives one 2 us pulse, style ignored.
// - external source for outputs takes output triggers from output terminal IN pin.
// - each output trigger drives output OUT pin as pulse or edge by style.
// - first-rank input trigger samples all sixteen inputs into first-rank register.
// - second-rank trigger copies first-rank register into matching second-rank register.
// - output trigger copies first-rank output register to second rank and pins.
// - after reset all three trigger sources are internal.
module rit_trigger_terminals
(
  input  wire logic                        CLK_I,
  input  wire logic                        SRST_I,
  input  wire logic                        CE_I,
  input  wire rit_pkg::rit_cfg_t           CFG_I,
  input  wire logic                        CFG_WE_I,
  input  wire logic                        INT_FIRST_FIRST_RANK_SOURCE_SELECT_I,
  input  wire logic                        INT_SECOND_IN_FIRST_RANK_SOURCE_SELECT_I,
  input  wire logic                        INT_SECOND_OUT_FIRST_RANK_SOURCE_SELECT_I,
  input  wire logic [rit_pkg::CHAN_W-1:0]  INPUT_CHANNELS_I,
  input  wire logic [rit_pkg::CHAN_W-1:0]  FIRST_OUT_DATA_I,
  input  wire logic                        FIRST_OUT_WE_I,
  input  wire logic                        FIRST_IN_FIRST_RANK_SOURCE_SELECT_N_I,
  input  wire logic                        SECOND_IN_FIRST_RANK_SOURCE_SELECT_N_I,
  input  wire logic                        SECOND_OUT_FIRST_RANK_SOURCE_SELECT_N_I,
  output logic                             FIRST_IN_FIRST_RANK_SOURCE_SELECT_N_O,
  output logic                             SECOND_IN_FIRST_RANK_SOURCE_SELECT_N_O,
  output logic                             SECOND_OUT_FIRST_RANK_SOURCE_SELECT_N_O,
  output rit_pkg::rit_cfg_t                CFG_O,
  output logic [rit_pkg::CHAN_W-1:0]       FIRST_IN_RANK_O,
  output logic [rit_pkg::CHAN_W-1:0]       SECOND_IN_RANK_O,
  output logic [rit_pkg::CHAN_W-1:0]       FIRST_OUT_RANK_O,
  output logic [rit_pkg::CHAN_W-1:0]       OUTPUT_CHANNELS_O
);

  rit_pkg::rit_cfg_t           cfg_r,   cfg_nxt;
  logic [2:0]                  sync1_r, sync1_nxt;
  logic [2:0]                  sync2_r, sync2_nxt;
  logic [2:0]                  prev_r,  prev_nxt;
  logic [2:0]                  ext_fall;
  logic                        trig1, trig2i, trig2o;
  logic [rit_pkg::CHAN_W-1:0]  fin_r,  fin_nxt;
  logic [rit_pkg::CHAN_W-1:0]  sin_r,  sin_nxt;
  logic [rit_pkg::CHAN_W-1:0]  fout_r, fout_nxt;
  logic [rit_pkg::CHAN_W-1:0]  sout_r, sout_nxt;
  rit_pkg::rit_pg_state_t      st_r   [3];
  rit_pkg::rit_pg_state_t      st_nxt [3];
  logic [rit_pkg::CNT_W-1:0]   cnt_r  [3];
  logic [rit_pkg::CNT_W-1:0]   cnt_nxt[3];
  logic [2:0]                  fire;
  logic [2:0]                  edge_style;
  logic [2:0]                  out_n_r, out_n_nxt;

  // next state of one trigger output generator
  function automatic rit_pkg::rit_pg_state_t pg_next(
    input rit_pkg::rit_pg_state_t st,
    input logic [rit_pkg::CNT_W-1:0] cnt,
    input logic go,
    input logic held);
    rit_pkg::rit_pg_state_t n;
    n = st;
    case (st)
      rit_pkg::PG_IDLE: if (go) n = held ? rit_pkg::PG_HELD : rit_pkg::PG_LOW;
      rit_pkg::PG_LOW:  if (cnt == 1) n = rit_pkg::PG_IDLE;
      rit_pkg::PG_HELD: if (go) n = held ? rit_pkg::PG_HELD : rit_pkg::PG_LOW;
      default:          n = rit_pkg::PG_IDLE;
    endcase
    return n;
  endfunction

  // configuration register, internal after reset
  always_comb
  begin
    cfg_nxt = CFG_WE_I ? CFG_I : cfg_r;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      cfg_r <= rit_pkg::CFG_RST;
    else if (CE_I)
      cfg_r <= cfg_nxt;
  end

  // two-flop synchronizers and falling edge detect on the IN pins
  always_comb
  begin
    sync1_nxt = {SECOND_OUT_FIRST_RANK_SOURCE_SELECT_N_I, SECOND_IN_FIRST_RANK_SOURCE_SELECT_N_I, FIRST_IN_FIRST_RANK_SOURCE_SELECT_N_I};
    sync2_nxt = sync1_r;
    prev_nxt  = sync2_r;
    ext_fall  = prev_r & ~sync2_r;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      prev_r  <= 3'h7;
    end
    else if (CE_I)
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
    end
  end

  // trigger source selection
  always_comb
  begin
    trig1  = (cfg_r.first_rank_source_select == rit_pkg::SRC_EXTERNAL)
             ? ext_fall[0] : INT_FIRST_FIRST_RANK_SOURCE_SELECT_I;
    trig2i = (cfg_r.second_rank_in_source_select == rit_pkg::SRC_EXTERNAL)
             ? ext_fall[1] : INT_SECOND_IN_FIRST_RANK_SOURCE_SELECT_I;
    trig2o = (cfg_r.second_rank_out_source_select == rit_pkg::SRC_EXTERNAL)
             ? ext_fall[2] : INT_SECOND_OUT_FIRST_RANK_SOURCE_SELECT_I;
  end

  // rank registers
  always_comb
  begin
    fin_nxt  = trig1 ? INPUT_CHANNELS_I : fin_r;
    sin_nxt  = trig2i ? fin_r : sin_r;
    fout_nxt = FIRST_OUT_WE_I ? FIRST_OUT_DATA_I : fout_r;
    sout_nxt = trig2o ? fout_r : sout_r;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      fin_r  <= rit_pkg::RANK_RST;
      sin_r  <= rit_pkg::RANK_RST;
      fout_r <= rit_pkg::RANK_RST;
      sout_r <= rit_pkg::RANK_RST;
    end
    else if (CE_I)
    begin
      fin_r  <= fin_nxt;
      sin_r  <= sin_nxt;
      fout_r <= fout_nxt;
      sout_r <= sout_nxt;
    end
  end

  // trigger output generators: pulse or held low edge
  always_comb
  begin
    fire       = {trig2o, trig2i, trig1};
    edge_style = {cfg_r.second_rank_out_style == rit_pkg::STYLE_EDGE,
                  1'b0,
                  cfg_r.first_rank_style == rit_pkg::STYLE_EDGE};
    for (int i = 0; i < 3; i++)
    begin
      st_nxt[i]  = pg_next(st_r[i], cnt_r[i], fire[i], edge_style[i]);
      cnt_nxt[i] = (st_nxt[i] == rit_pkg::PG_LOW && st_r[i] != rit_pkg::PG_LOW)
                   ? rit_pkg::PULSE_LEN
                   : (st_r[i] == rit_pkg::PG_LOW ? cnt_r[i] - 1'b1 : cnt_r[i]);
      out_n_nxt[i] = (st_nxt[i] == rit_pkg::PG_IDLE);  // flop: no glitch on held to low
    end
  end

  always_ff @(posedge CLK_I)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (SRST_I)
      begin
        st_r[i]  <= rit_pkg::PG_IDLE;
        cnt_r[i] <= '0;
        out_n_r[i] <= 1'b1;
      end
      else if (CE_I)
      begin
        st_r[i]  <= st_nxt[i];
        cnt_r[i] <= cnt_nxt[i];
        out_n_r[i] <= out_n_nxt[i];
      end
    end
  end

  // outputs
  always_comb
  begin
    FIRST_IN_FIRST_RANK_SOURCE_SELECT_N_O   = out_n_r[0];
    SECOND_IN_FIRST_RANK_SOURCE_SELECT_N_O  = out_n_r[1];
    SECOND_OUT_FIRST_RANK_SOURCE_SELECT_N_O = out_n_r[2];
    CFG_O               = cfg_r;
    FIRST_IN_RANK_O     = fin_r;
    SECOND_IN_RANK_O    = sin_r;
    FIRST_OUT_RANK_O    = fout_r;
    OUTPUT_CHANNELS_O   = sout_r;
  end

  // helper: cycles spent low in pulse state
  logic [rit_pkg::CNT_W-1:0] low_len_r [3];
  always_ff @(posedge CLK_I)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (SRST_I || st_r[i] != rit_pkg::PG_LOW)
        low_len_r[i] <= '0;
      else if (CE_I)
        low_len_r[i] <= low_len_r[i] + 1'b1;
    end
  end

  // second-rank input out pin low as a pulse, never held
  sequence s_second_in_pulse;
    !SECOND_IN_FIRST_RANK_SOURCE_SELECT_N_O ##0 st_r[1] == rit_pkg::PG_LOW;
  endsequence

  reset_sources_a: assert property (@(posedge CLK_I)
    $fell(SRST_I) |-> cfg_r == rit_pkg::CFG_RST)
    else $error("sources not internal after reset");
  first_ext_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && cfg_r.first_rank_source_select == rit_pkg::SRC_EXTERNAL && ext_fall[0]
    |=> fin_r == $past(INPUT_CHANNELS_I))
    else $error("external first trigger not taken");
  sample_in_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && trig1 |=> FIRST_IN_RANK_O == $past(INPUT_CHANNELS_I))
    else $error("inputs not sampled");
  copy_in_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && trig2i |=> sin_r == $past(fin_r))
    else $error("second input rank not copied");
  copy_out_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && trig2o |=> OUTPUT_CHANNELS_O == $past(fout_r))
    else $error("output rank not copied");
  pulse_max_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    low_len_r[0] <= rit_pkg::PULSE_MAX_CYC && low_len_r[1] <= rit_pkg::PULSE_MAX_CYC
    && low_len_r[2] <= rit_pkg::PULSE_MAX_CYC)
    else $error("pulse too long");
  pulse_min_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && st_r[0] == rit_pkg::PG_LOW && st_nxt[0] == rit_pkg::PG_IDLE
    |-> low_len_r[0] + 1 >= rit_pkg::PULSE_MIN_CYC)
    else $error("pulse too short");
  second_in_pulse_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && trig2i && st_r[1] == rit_pkg::PG_IDLE |=> s_second_in_pulse)
    else $error("second input pulse missing");
  first_edge_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && trig1 && cfg_r.first_rank_style == rit_pkg::STYLE_EDGE
    |=> !FIRST_IN_FIRST_RANK_SOURCE_SELECT_N_O)
    else $error("first output not low");
  out_edge_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && trig2o |=> !SECOND_OUT_FIRST_RANK_SOURCE_SELECT_N_O)
    else $error("output trigger not driven");
  sync_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && ext_fall[0] |=> !ext_fall[0])
    else $error("one edge gave two triggers");

endmodule
